// [design/aif_pkg.sv]
// Shared constants and types of the ADC interrupt flag logic.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none

package aif_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LOCK = 4'h4;
  localparam logic [3:0] OFS_CMD  = 4'h8;
  localparam logic [3:0] OFS_IRQ  = 4'hc;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int         CTRL_STP_EN  = 0;  // start_pulse_enable
  localparam int         CTRL_IRQ_M1  = 1;  // Pin mode bit 1
  localparam int         CTRL_BS_EN   = 2;  // Bitstream on pin
  localparam int         CTRL_MODE_LO = 3;  // Conversion mode, 2 bits
  localparam logic [7:0] CTRL_MASK    = 8'h1f;
  localparam logic [7:0] CTRL_RST     = 8'h01;
  localparam logic [7:0] LOCK_KEY     = 8'ha5;
  localparam int         CMD_START    = 0;
  localparam int         IRQ_POR      = 0;
  localparam int         IRQ_CRC      = 1;

  // ---------------------------------------------------------------------
  // Timing counts in modulator clock periods
  // ---------------------------------------------------------------------
  localparam logic [8:0] STARTUP_MCLK = 9'h100;
  localparam logic [8:0] STP_MCLK     = 9'h001;

  // ---------------------------------------------------------------------
  // Checksum settings
  // ---------------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'h0,
    MODE_CONT    = 2'h1,
    MODE_SCAN    = 2'h2
  } aif_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_PULSE = 2'h3,
    ST_RUN   = 2'h2
  } aif_st_t;

endpackage

`default_nettype wire

// [design/aif_sync3.sv]
// Three-stage synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_i.
`default_nettype none

module aif_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } aif_sync_t;

  aif_sync_t cur_ff;
  aif_sync_t nxt_ff;

  // Shift in; output follows once stages two and three agree
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.sh = {cur_ff.sh[1:0], d_i};
    if (cur_ff.sh[1] == cur_ff.sh[2])
    begin
      nxt_ff.q = cur_ff.sh[2];
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign q_o = cur_ff.q;

endmodule // aif_sync3

`default_nettype wire

// [design/aif_crc16.sv]
// Combinational CRC-16 over a parallel data word, MSB first.
// Assumes the caller registers the result where timing needs it.
`default_nettype none

module aif_crc16 #(
  parameter int          DATA_W = 8,
  parameter logic [15:0] POLY   = 16'h8005,
  parameter logic [15:0] INIT   = 16'hffff
) (
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [15:0]       crc_o
);

  // Bitwise division loop
  always_comb
  begin
    logic [15:0] c;
    logic        fb;
    c  = INIT;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--)
    begin
      fb = c[15] ^ data_i[i];
      c  = {c[14:0], 1'b0};
      if (fb)
      begin
        c = c ^ POLY;
      end
    end
    crc_o = c;
  end

endmodule // aif_crc16

`default_nettype wire

// [design/aif_irq_top.sv]
// Interrupt flag logic: start pulse, power-loss and checksum error.
// Assumes Avalon-MM master on SYS_CLK_I; pins are asynchronous.
//
// Notes on behaviour
// (R1) Conversion start appears only on the pin, never in status flags.
// (R2) start_pulse_enable gates the start pulse; 1 enables, reset value 1.
// (R3) One-shot/continuous: pulse after 256 modulator clocks of start-up.
// (R4) Scan mode: pulse only at first conversion of first scan cycle.
// (R5) Start pulse drives pin low, released by itself after fixed width.
// (R6) Power-loss flag reads 0 in first status byte, then 1.
// (R7) Power loss between status bytes shows 0 in the later byte.
// (R8) No serial data while supplies are below threshold.
// (R9) Power-loss register bit is 0 after power-up, 1 after a full read.
// (R10) Power loss between register reads shows 0 on the second read.
// (R11) Pin goes low at once when either supply drops below threshold.
// (R12) Pin power-loss cleared only by chip-select fall with supplies ok.
// (R13) Power loss has top pin priority, even over the bitstream.
// (R14) Register map checksum computed continuously; mismatch raises error.
// (R15) Checksum error reads 0 in next status byte, then 1.
// (R16) Checksum error register bit 0 after error, 1 after a full read.
// (R17) Pin checksum error held until unlock key or start command.
// (R18) Unlock stops checksum; start command restarts it; both clear error.
// (R19) Checksum error outranks all but power loss, and the bitstream.
// (R20) Host restarts conversion if clock ran before lock, clearing error.
// (R21) Pin mode bit 1 set lets only power loss and checksum pull low; the bitstream still drives the pin when CTRL_BS_EN is set.
// (R22) Status flags latched at address detect, cleared at byte end.
// (R23) Checksum works only when locked; map is unlocked at power-up.
// (R24) Pin low while any enabled source is active, else released high.
`default_nettype none

module aif_irq_top
  import aif_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        MOD_CLK_I,
  input  wire logic        CS_N_I,
  input  wire logic        AVDD_OK_I,
  input  wire logic        DVDD_OK_I,
  input  wire logic        MOD_BITSTREAM_I,
  input  wire logic [7:0]  CFG_FAULT_I,
  input  wire logic        STAT_LATCH_I,
  input  wire logic        STAT_DONE_I,
  output logic      [1:0]  STAT_FLAGS_O,
  output logic             SERIAL_EN_O,
  output logic             IRQ_N_O
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    aif_st_t     st;
    logic [8:0]  cnt;
    logic [7:0]  ctrl;
    logic        locked;
    logic [15:0] ref_crc;
    logic        err_lvl;
    logic        pwr_pin;
    logic        crc_pin;
    logic        pend_por_sb;
    logic        pend_crc_sb;
    logic        pend_por_rg;
    logic        pend_crc_rg;
    logic [1:0]  stat_flags;
    logic        serial_en;
    logic        ack;
    logic [31:0] rdata;
    logic        mclk_q;
    logic        cs_q;
    logic        sup_q;
  } aif_main_t;

  aif_main_t   cur_ff;
  aif_main_t   nxt_ff;

  logic        mclk_s;
  logic        cs_s;
  logic        avdd_s;
  logic        dvdd_s;
  logic        both_ok;
  logic        mclk_rise;
  logic        cs_fall;
  logic        pwr_evt;
  logic        req;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_lock;
  logic        start_cmd;
  logic        unlock;
  logic        lock;
  logic        rd_irq;
  logic [15:0] crc_now;
  logic        err_now;
  logic        crc_evt;
  logic        stp_drive;
  logic        top_drive;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  aif_sync3 u_sync_mclk (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (MOD_CLK_I),
    .q_o     (mclk_s)
  );

  aif_sync3 u_sync_cs (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (CS_N_I),
    .q_o     (cs_s)
  );

  aif_sync3 u_sync_avdd (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (AVDD_OK_I),
    .q_o     (avdd_s)
  );

  aif_sync3 u_sync_dvdd (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (DVDD_OK_I),
    .q_o     (dvdd_s)
  );

  // ---------------------------------------------------------------------
  // Checksum over the configuration, disturbed by the fault input
  // ---------------------------------------------------------------------
  aif_crc16 #(
    .DATA_W (8),
    .POLY   (CRC_POLY),
    .INIT   (CRC_INIT)
  ) u_crc (
    .data_i (cur_ff.ctrl ^ CFG_FAULT_I),
    .crc_o  (crc_now)
  );

  // ---------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------
  // Edges of the synchronised pins
  assign both_ok   = avdd_s & dvdd_s;
  assign mclk_rise = mclk_s & ~cur_ff.mclk_q;
  assign cs_fall   = ~cs_s & cur_ff.cs_q;
  assign pwr_evt   = ~both_ok & cur_ff.sup_q;

  // Bus strobes; an access takes effect on its second cycle
  assign req       = AVS_READ_I | AVS_WRITE_I;
  assign wr        = AVS_WRITE_I & cur_ff.ack & AVS_BYTEENABLE_I[0];
  assign wr_ctrl   = wr & (AVS_ADDRESS_I == OFS_CTRL) & ~cur_ff.locked;
  assign wr_lock   = wr & (AVS_ADDRESS_I == OFS_LOCK);
  assign start_cmd = wr & (AVS_ADDRESS_I == OFS_CMD)
                   & AVS_WRITEDATA_I[CMD_START];
  assign unlock    = wr_lock & (AVS_WRITEDATA_I[7:0] == LOCK_KEY);
  assign lock      = wr_lock & ~unlock;
  assign rd_irq    = AVS_READ_I & cur_ff.ack
                   & (AVS_ADDRESS_I == OFS_IRQ);

  // Checksum mismatch only counts while locked
  assign err_now   = cur_ff.locked & (crc_now != cur_ff.ref_crc); // see (R23)
  assign crc_evt   = err_now & ~cur_ff.err_lvl
                   & ~start_cmd & ~unlock; // see (R14)

  // ---------------------------------------------------------------------
  // Pin priority
  // ---------------------------------------------------------------------
  // Start pulse only reaches the pin, gated by enable and mode bit 1
  assign stp_drive = (cur_ff.st == ST_PULSE)
                   & cur_ff.ctrl[CTRL_STP_EN]
                   & ~cur_ff.ctrl[CTRL_IRQ_M1]; // see (R1) see (R2) see (R21)
  assign top_drive = cur_ff.pwr_pin | cur_ff.crc_pin; // see (R13) see (R19)

  // Power loss, then checksum, then bitstream or start pulse
  always_comb
  begin
    if (top_drive)
    begin
      IRQ_N_O = 1'b0; // see (R24)
    end
    else if (cur_ff.ctrl[CTRL_BS_EN])
    begin
      IRQ_N_O = MOD_BITSTREAM_I;
    end
    else
    begin
      IRQ_N_O = ~stp_drive; // see (R5)
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.mclk_q    = mclk_s;
    nxt_ff.cs_q      = cs_s;
    nxt_ff.sup_q     = both_ok;
    nxt_ff.err_lvl   = err_now;
    nxt_ff.serial_en = both_ok; // see (R8)
    nxt_ff.ack       = req & ~cur_ff.ack;

    // Conversion start sequencer, one pulse per start command
    case (cur_ff.st)
      ST_IDLE:
      begin
        nxt_ff.cnt = 9'h000;
      end
      ST_WAIT:
      begin
        if (mclk_rise)
        begin
          if (cur_ff.cnt == STARTUP_MCLK - 9'h001) // see (R3)
          begin
            nxt_ff.st  = ST_PULSE;
            nxt_ff.cnt = 9'h000;
          end
          else
          begin
            nxt_ff.cnt = cur_ff.cnt + 9'h001;
          end
        end
      end
      ST_PULSE:
      begin
        if (mclk_rise)
        begin
          if (cur_ff.cnt == STP_MCLK - 9'h001) // see (R5)
          begin
            nxt_ff.cnt = 9'h000;
            if (cur_ff.ctrl[CTRL_MODE_LO +: 2] == MODE_ONESHOT)
            begin
              nxt_ff.st = ST_IDLE;
            end
            else
            begin
              nxt_ff.st = ST_RUN; // see (R4)
            end
          end
          else
          begin
            nxt_ff.cnt = cur_ff.cnt + 9'h001;
          end
        end
      end
      ST_RUN:
      begin
        nxt_ff.cnt = 9'h000;
      end
      default:
      begin
        nxt_ff.st  = ST_IDLE;
        nxt_ff.cnt = 9'h000;
      end
    endcase
    if (start_cmd)
    begin
      nxt_ff.st  = ST_WAIT;
      nxt_ff.cnt = 9'h000;
    end

    // Register map writes and lock key
    if (wr_ctrl)
    begin
      nxt_ff.ctrl = AVS_WRITEDATA_I[7:0] & CTRL_MASK;
    end
    if (unlock)
    begin
      nxt_ff.locked = 1'b0; // see (R18)
    end
    else if (lock)
    begin
      nxt_ff.locked  = 1'b1;
      nxt_ff.ref_crc = crc_now;
    end
    if (start_cmd & cur_ff.locked)
    begin
      nxt_ff.ref_crc = crc_now; // see (R18) see (R20)
    end

    // Pin power loss: set wins over the chip-select clear
    nxt_ff.pwr_pin = ~both_ok
                   | (cur_ff.pwr_pin & ~(cs_fall & both_ok)); // see (R11) see (R12)

    // Pin checksum error held until unlock or start
    if (start_cmd | unlock)
    begin
      nxt_ff.crc_pin = 1'b0; // see (R17)
    end
    else
    begin
      nxt_ff.crc_pin = cur_ff.crc_pin | crc_evt;
    end

    // Status byte: latch at address detect, clear at byte end
    if (STAT_LATCH_I & both_ok)
    begin
      nxt_ff.stat_flags = {~cur_ff.pend_crc_sb, ~cur_ff.pend_por_sb}; // see (R22)
    end
    nxt_ff.pend_por_sb = (cur_ff.pend_por_sb & ~STAT_DONE_I)
                       | pwr_evt; // see (R6) see (R7)
    nxt_ff.pend_crc_sb = (cur_ff.pend_crc_sb & ~STAT_DONE_I)
                       | crc_evt; // see (R15)

    // Interrupt register: cleared once its read completes
    nxt_ff.pend_por_rg = (cur_ff.pend_por_rg & ~rd_irq)
                       | pwr_evt; // see (R9) see (R10)
    nxt_ff.pend_crc_rg = (cur_ff.pend_crc_rg & ~rd_irq)
                       | crc_evt; // see (R16)

    // Read data captured in the first access cycle
    if (req & ~cur_ff.ack)
    begin
      case (AVS_ADDRESS_I)
        OFS_CTRL: nxt_ff.rdata = {24'h000000, cur_ff.ctrl};
        OFS_LOCK: nxt_ff.rdata = {31'h00000000, cur_ff.locked};
        OFS_IRQ:
        begin
          nxt_ff.rdata = 32'h00000000;
          nxt_ff.rdata[IRQ_POR] = ~cur_ff.pend_por_rg;
          nxt_ff.rdata[IRQ_CRC] = ~cur_ff.pend_crc_rg;
        end
        default:  nxt_ff.rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cur_ff             <= '0;
      cur_ff.st          <= ST_IDLE;
      cur_ff.ctrl        <= CTRL_RST;
      cur_ff.pwr_pin     <= 1'b1;
      cur_ff.pend_por_sb <= 1'b1;
      cur_ff.pend_por_rg <= 1'b1;
      cur_ff.stat_flags  <= 2'h3;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs
  assign AVS_READDATA_O    = cur_ff.rdata;
  assign AVS_WAITREQUEST_O = req & ~cur_ff.ack;
  assign STAT_FLAGS_O      = cur_ff.stat_flags;
  assign SERIAL_EN_O       = cur_ff.serial_en;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_pwr_pin_low: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    !both_ok |=> !IRQ_N_O) // see (R11)
    else $error("pin not low on supply drop");

  a_pwr_pin_hold: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_N_I)
    cur_ff.pwr_pin && !(cs_fall && both_ok) |=> cur_ff.pwr_pin) // see (R12)
    else $error("power-loss pin cleared without cs fall");

  a_crc_over_rest: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_N_I)
    cur_ff.crc_pin |-> !IRQ_N_O) // see (R19)
    else $error("checksum error not on pin");

  a_mode_mask: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    cur_ff.ctrl[CTRL_IRQ_M1] && !top_drive && !cur_ff.ctrl[CTRL_BS_EN]
    |-> IRQ_N_O) // see (R21)
    else $error("masked source pulled pin low");

  a_startup_delay: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_N_I)
    cur_ff.st == ST_WAIT && mclk_rise && !start_cmd
    && cur_ff.cnt == STARTUP_MCLK - 9'h001 |=> cur_ff.st == ST_PULSE) // see (R3)
    else $error("start pulse not after start-up delay");

  a_low_has_cause: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_N_I)
    !IRQ_N_O |-> top_drive || (cur_ff.ctrl[CTRL_BS_EN] && !MOD_BITSTREAM_I)
    || (cur_ff.st == ST_PULSE && cur_ff.ctrl[CTRL_STP_EN])) // see (R2) see (R24)
    else $error("pin low with no source");

  a_sb_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    STAT_DONE_I && !pwr_evt |=> !cur_ff.pend_por_sb) // see (R6) see (R22)
    else $error("power-loss flag not cleared after byte");

  a_unlock_clears: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_N_I)
    unlock |=> !cur_ff.crc_pin && !cur_ff.locked) // see (R17)
    else $error("unlock did not clear checksum error");

  a_read_clears: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    rd_irq && !crc_evt |=> !cur_ff.pend_crc_rg) // see (R16)
    else $error("register read did not clear checksum bit");

  a_one_pulse: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    cur_ff.st == ST_RUN && !start_cmd |=> cur_ff.st == ST_RUN) // see (R4)
    else $error("second start pulse without start command");

endmodule // aif_irq_top

`default_nettype wire

// [bench/aif_host.sv]
// Host model: status byte frames and chip-select taps.
// Assumes the device answers only while both supplies are good.
`default_nettype none

module aif_host (
  input  wire logic       clk_i,
  input  wire logic [1:0] flags_i,
  output logic            cs_n_o,
  output logic            latch_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial
  begin
    cs_n_o  = 1'b1;
    latch_o = 1'b0;
    done_o  = 1'b0;
  end

  // Chip-select tap alone, long enough to pass the synchroniser
  task automatic tap;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  // Select, latch at address detect, take flags, end byte
  task automatic frame(output logic [1:0] f);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    latch_o <= 1'b1;
    @(posedge clk_i);
    latch_o <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    f = flags_i;
    @(posedge clk_i);
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // aif_host

`default_nettype wire

// [bench/tb.sv]
// Testbench: register bus, start pulse, checksum and power loss.
// Assumes aif_pkg, the design and aif_host are compiled first.
`default_nettype none

module tb;
  import aif_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst_n, mclk, rd, wr, avdd, dvdd, bits, hit;
  logic        wait_o, ser_en, irq_n, cs_n, latch, done;
  logic [3:0]  addr, be, bew;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  fault;
  logic [1:0]  flags, f;
  int          n_errors, num_checks, mrise, m0, t;
  logic [7:0]  ctl [5] = '{8'h01, 8'h09, 8'h11, 8'h00, 8'h03};
  logic        pex [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  // ------------------------------------------------------------
  // Clocks: system 5 ns, modulator 80 ns with unrelated phase
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;
  initial
  begin
    mclk = 1'b0;
    mrise = 0;
    #13;
    forever #40 mclk = ~mclk;
  end
  always @(posedge mclk) mrise++;

  // Device and host
  aif_irq_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o),
    .MOD_CLK_I(mclk), .CS_N_I(cs_n), .AVDD_OK_I(avdd),
    .DVDD_OK_I(dvdd), .MOD_BITSTREAM_I(bits), .CFG_FAULT_I(fault),
    .STAT_LATCH_I(latch), .STAT_DONE_I(done), .STAT_FLAGS_O(flags),
    .SERIAL_EN_O(ser_en), .IRQ_N_O(irq_n));
  aif_host host (.clk_i(clk), .flags_i(flags), .cs_n_o(cs_n),
    .latch_o(latch), .done_o(done));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Avalon-MM cycle held until waitrequest is sampled low at a rising
  // edge; values read just after the edge are still the pre-edge ones
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdat <= d;
    be <= bew;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 20)
      begin
        n_errors++;
        test_done();
      end
    end while (wait_o !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Wait for a pin level; a miss ends the run when it must come
  task automatic seek(input logic v, input int lim, input bit must);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(negedge clk);
      hit = (irq_n === v);
    end
    if (!hit && must)
    begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic wser;
    for (int i = 0; i < 40 && ser_en !== 1'b1; i++) @(negedge clk);
    chk(ser_en, 1'b1);
    if (ser_en !== 1'b1)
    begin
      test_done();
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {rd, wr, bits} = 3'h0;
    {avdd, dvdd} = 2'h3;
    addr = 4'h0;
    wdat = 32'h0;
    fault = 8'h00;
    be = 4'hf;
    bew = 4'hf;
    n_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, power-up flags and pin
    wser();
    chk(irq_n, 1'b0);
    rdc(OFS_CTRL, 32'h01);
    bew = 4'h0;
    bus(1'b1, OFS_CTRL, 32'h00);
    bew = 4'hf;
    rdc(OFS_CTRL, 32'h01);
    rdc(OFS_LOCK, 32'h00);
    rdc(4'h2, 32'h00);
    rdc(OFS_IRQ, 32'h02);
    rdc(OFS_IRQ, 32'h03);
    host.frame(f);
    chk(f, 2'h2);
    chk(irq_n, 1'b1);
    host.frame(f);
    chk(f, 2'h3);
    $display("test 1 done");
    // Start pulse per mode and enable
    foreach (ctl[i])
    begin
      bus(1'b1, OFS_CTRL, ctl[i]);
      m0 = mrise;
      bus(1'b1, OFS_CMD, 32'h01);
      seek(1'b0, 6000, 1'b0);
      chk(hit, pex[i]);
      if (hit)
      begin
        t = mrise - m0;
        chk(t >= 256 && t <= 257, 1'b1);
        for (t = 0; t < 40 && irq_n === 1'b0; t++) @(negedge clk);
        chk(t >= 14 && t <= 18, 1'b1);
      end
      host.frame(f);
      chk(f, 2'h3);
    end
    $display("test 2 done");
    // Bitstream on the pin
    bus(1'b1, OFS_CTRL, 32'h05);
    @(posedge clk) bits <= 1'b0;
    @(negedge clk) chk(irq_n, 1'b0);
    @(posedge clk) bits <= 1'b1;
    @(negedge clk) chk(irq_n, 1'b1);
    // Checksum error: unlocked, locked, hold, clears
    @(posedge clk) fault <= 8'h01;
    seek(1'b0, 50, 1'b0);
    chk(hit, 1'b0);
    @(posedge clk) fault <= 8'h00;
    bus(1'b1, OFS_LOCK, 32'h00);
    rdc(OFS_LOCK, 32'h01);
    @(posedge clk) fault <= 8'h01;
    seek(1'b0, 20, 1'b1);
    @(posedge clk) fault <= 8'h00;
    seek(1'b1, 50, 1'b0);
    chk(hit, 1'b0);
    host.frame(f);
    chk(f, 2'h1);
    host.frame(f);
    chk(f, 2'h3);
    rdc(OFS_IRQ, 32'h01);
    rdc(OFS_IRQ, 32'h03);
    bus(1'b1, OFS_CMD, 32'h01);
    seek(1'b1, 20, 1'b1);
    @(posedge clk) fault <= 8'h02;
    seek(1'b0, 20, 1'b1);
    @(posedge clk) fault <= 8'h00;
    bus(1'b1, OFS_LOCK, {24'h0, LOCK_KEY});
    seek(1'b1, 20, 1'b1);
    rdc(OFS_LOCK, 32'h00);
    $display("test 3 done");
    // Supply loss over the bitstream
    @(posedge clk) avdd <= 1'b0;
    seek(1'b0, 20, 1'b1);
    @(posedge clk)
    begin
      avdd <= 1'b1;
      dvdd <= 1'b0;
    end
    repeat (10) @(posedge clk);
    chk(ser_en, 1'b0);
    host.tap();
    chk(irq_n, 1'b0);
    @(posedge clk) dvdd <= 1'b1;
    wser();
    chk(irq_n, 1'b0);
    host.frame(f);
    chk(f, 2'h0);
    chk(irq_n, 1'b1);
    rdc(OFS_IRQ, 32'h00);
    $display("test 4 done");
    test_done();
  end
endmodule // tb

`default_nettype wire
